/* File: design/lsd_core.sv */
// Status, event, output shutdown and front panel lock logic of the laser driver.
`timescale 1ns/1ps
`default_nettype none
// What this block does
// - In pulsed mode, sync output rises a set delay after each pulse rising edge.
// - A delay query returns the stored sync output delay.
// - Display write 0 locks panel and blanks display; 1 restores both.
// - Panel stays locked until host writes 1 or power cycles.
// - Condition mask selects conditions feeding the summary status bit.
// - Event mask selects latched events feeding the summary status bit.
// - Queries return the stored condition and event masks.
// - Laser output goes off while a fault's shutdown mask bit is set.
// - Shutdown mask bits 1, 4, 7, 8, 12, 15 are always set.
// - Shutdown mask bit map covers each fault; bits 5 and 6 unused.
// - Shutdown mask resets to 40350.
// - A shutdown mask query returns its current value.
// - Event bits latch their documented events; bits 5, 6, 12 and 15 unused.
// - An event query returns the full latched event register.
// - After an event read every event bit clears, except bits whose event arrives in the read cycle.
module lsd_core
    import lsd_pkg::*;
#(
    parameter int MAX_DLY_CYC = SYNC_DLY_MAX_CYC  // Longest sync delay in cycles.
)(
    input  wire logic              clk_sys,            // System clock, 25 MHz.
    input  wire logic              rst,                // Asynchronous reset, active high.
    input  wire logic              cmd_valid,          // Host command strobe.
    input  wire logic [3:0]        cmd_op,             // Command code.
    input  wire logic [31:0]       cmd_data,           // Command argument.
    output logic                   rsp_valid,          // Query answer strobe.
    output logic      [31:0]       rsp_data,           // Query answer value.
    input  wire logic              pulsed_drive_mode,  // Pulsed drive mode pin.
    input  wire logic              drive_pulse,        // Output pulse pin.
    input  wire logic [STAT_W-1:0] cond_in,            // Laser condition levels.
    input  wire logic [STAT_W-1:0] event_in,           // Laser event indications.
    input  wire logic [STAT_W-1:0] fault_in,           // Fault levels for shutdown.
    output logic                   pulse_sync_output,  // Delayed pulse sync output.
    output logic                   laser_off,          // Laser output forced off.
    output logic                   panel_locked,       // Display blanked and panel locked.
    output logic                   status_summary      // Laser summary status bit.
);
    typedef struct packed {
        logic [1:0]        mode_s;
        logic [2:0]        pulse_s;
        logic [STAT_W-1:0] cond_s1;
        logic [STAT_W-1:0] cond_s2;
        logic [STAT_W-1:0] evt_s1;
        logic [STAT_W-1:0] evt_s2;
        logic [STAT_W-1:0] flt_s1;
        logic [STAT_W-1:0] flt_s2;
        logic [DLY_W-1:0]  dly;
        logic              disp_en;
        logic              locked;
        logic [STAT_W-1:0] cond_en;
        logic [STAT_W-1:0] evt_en;
        logic [STAT_W-1:0] outoff;
        logic [STAT_W-1:0] evt;
        logic              fire;
        logic              off;
        logic              summary;
        logic              rsp_v;
        logic [31:0]       rsp_d;
    } lsd_core_st_t;

    lsd_core_st_t     s_r;
    lsd_core_st_t     s_nxt;
    lsd_sync_if       sif ();
    logic             take;
    logic             evt_read;
    lsd_cmd_t         op;

    assign op       = lsd_cmd_t'(cmd_op);
    assign take     = cmd_valid;
    assign evt_read = take && op == CMD_GET_EVT;

    always_comb begin
        s_nxt = s_r;
        // Every pin input passes two flip-flops before anything reads it.
        s_nxt.mode_s  = {s_r.mode_s[0], pulsed_drive_mode};
        s_nxt.pulse_s = {s_r.pulse_s[1], s_r.pulse_s[0], drive_pulse};
        s_nxt.cond_s1 = cond_in;
        s_nxt.cond_s2 = s_r.cond_s1;
        s_nxt.evt_s1  = event_in;
        s_nxt.evt_s2  = s_r.evt_s1;
        s_nxt.flt_s1  = fault_in;
        s_nxt.flt_s2  = s_r.flt_s1;

        s_nxt.fire  = s_r.pulse_s[1] && !s_r.pulse_s[2];
        s_nxt.rsp_v = 1'b0;

        if (take) begin
            unique case (op)
                CMD_SET_DLY: begin
                    if (cmd_data > 32'(MAX_DLY_CYC)) begin
                        s_nxt.dly = DLY_W'(MAX_DLY_CYC);
                    end else begin
                        s_nxt.dly = cmd_data[DLY_W-1:0];
                    end
                end
                CMD_GET_DLY:     s_nxt.rsp_d = 32'(s_r.dly);
                CMD_SET_DISP:    s_nxt.disp_en = cmd_data[0];
                CMD_GET_DISP:    s_nxt.rsp_d = 32'(s_r.disp_en);
                CMD_SET_COND_EN: s_nxt.cond_en = cmd_data[STAT_W-1:0];
                CMD_GET_COND_EN: s_nxt.rsp_d = 32'(s_r.cond_en);
                CMD_SET_EVT_EN:  s_nxt.evt_en = cmd_data[STAT_W-1:0] & EVT_VALID;
                CMD_GET_EVT_EN:  s_nxt.rsp_d = 32'(s_r.evt_en);
                // Forced bits are stored set, so a query shows the mask actually in force.
                CMD_SET_OUTOFF:  s_nxt.outoff = (cmd_data[STAT_W-1:0] & OUTOFF_VALID) | OUTOFF_FORCED;
                CMD_GET_OUTOFF:  s_nxt.rsp_d = 32'(s_r.outoff);
                CMD_GET_EVT:     s_nxt.rsp_d = 32'(s_r.evt);
                default: ;
            endcase
            s_nxt.rsp_v = !op[0] ? 1'b0 : (op <= CMD_GET_EVT);
            if (op == CMD_GET_EVT) begin
                s_nxt.rsp_v = 1'b1;
            end
        end

        // A new event in the read cycle survives the clear.
        s_nxt.evt = (evt_read ? '0 : s_r.evt) | (s_r.evt_s2 & EVT_VALID);

        s_nxt.off     = |(s_r.flt_s2 & s_r.outoff);
        s_nxt.summary = |(s_r.evt & s_r.evt_en) | |(s_r.cond_s2 & s_r.cond_en);
        // The lock flag is kept as its own flop so the output needs no inverter.
        s_nxt.locked  = !s_nxt.disp_en;
    end

    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            s_r         <= '0;
            s_r.disp_en <= DISP_RESET;
            s_r.locked  <= !DISP_RESET;
            s_r.cond_en <= MASK_RESET;
            s_r.evt_en  <= MASK_RESET;
            s_r.outoff  <= OUTOFF_RESET;
        end else begin
            s_r <= s_nxt;
        end
    end

    assign sif.delay  = s_r.dly;
    assign sif.enable = s_r.mode_s[1];
    assign sif.fire   = s_r.fire;

    lsd_sync_timer u_timer (
        .clk_sys (clk_sys),
        .rst     (rst),
        .sif     (sif.tmr)
    );

    assign rsp_valid         = s_r.rsp_v;
    assign rsp_data          = s_r.rsp_d;
    assign pulse_sync_output = sif.sync_out;
    assign laser_off         = s_r.off;
    assign panel_locked      = s_r.locked;
    assign status_summary    = s_r.summary;

    property p_forced;
        @(posedge clk_sys) disable iff (rst)
        (s_r.outoff & OUTOFF_FORCED) == OUTOFF_FORCED;
    endproperty
    a_forced: assert property (p_forced) else $error("forced shutdown bit cleared");

    property p_shutdown;
        @(posedge clk_sys) disable iff (rst)
        |(s_r.flt_s2 & s_r.outoff) |=> laser_off;
    endproperty
    a_shutdown: assert property (p_shutdown) else $error("masked fault did not turn laser off");

    property p_evt_sticky;
        @(posedge clk_sys) disable iff (rst)
        !evt_read |=> (s_r.evt & $past(s_r.evt)) == $past(s_r.evt);
    endproperty
    a_evt_sticky: assert property (p_evt_sticky) else $error("event bit lost without a read");

    property p_evt_clear;
        @(posedge clk_sys) disable iff (rst)
        evt_read && (s_r.evt_s2 & EVT_VALID) == '0 |=> s_r.evt == '0;
    endproperty
    a_evt_clear: assert property (p_evt_clear) else $error("event register not cleared by read");

    property p_evt_read;
        @(posedge clk_sys) disable iff (rst)
        evt_read |=> rsp_valid && rsp_data == 32'($past(s_r.evt));
    endproperty
    a_evt_read: assert property (p_evt_read) else $error("event query answer wrong");

    property p_lock_hold;
        @(posedge clk_sys) disable iff (rst)
        panel_locked && !(take && op == CMD_SET_DISP && cmd_data[0]) |=> panel_locked;
    endproperty
    a_lock_hold: assert property (p_lock_hold) else $error("panel unlocked without host write");

    property p_disp_set;
        @(posedge clk_sys) disable iff (rst)
        take && op == CMD_SET_DISP |=> panel_locked == !$past(cmd_data[0]);
    endproperty
    a_disp_set: assert property (p_disp_set) else $error("display write not applied");

    property p_summary;
        @(posedge clk_sys) disable iff (rst)
        1'b1 |=> status_summary == (|($past(s_r.evt) & $past(s_r.evt_en)) | |($past(s_r.cond_s2) & $past(s_r.cond_en)));
    endproperty
    a_summary: assert property (p_summary) else $error("summary status mismatch");

    property p_mask_query;
        @(posedge clk_sys) disable iff (rst)
        take && op == CMD_GET_COND_EN |=> rsp_valid && rsp_data == 32'($past(s_r.cond_en));
    endproperty
    a_mask_query: assert property (p_mask_query) else $error("condition mask query wrong");

    property p_outoff_hold;
        @(posedge clk_sys) disable iff (rst)
        !(take && op == CMD_SET_OUTOFF) |=> $stable(s_r.outoff);
    endproperty
    a_outoff_hold: assert property (p_outoff_hold) else $error("shutdown mask changed unasked");

    property p_dly_query;
        @(posedge clk_sys) disable iff (rst)
        take && op == CMD_GET_DLY |=> rsp_data == 32'($past(s_r.dly));
    endproperty
    a_dly_query: assert property (p_dly_query) else $error("delay query wrong");
endmodule
`default_nettype wire

/* File: design/lsd_pkg.sv */
// Constants, commands and state codes for the laser status, event and shutdown block.
package lsd_pkg;
    localparam int          CLK_HZ           = 25_000_000;
    localparam int          SYNC_DLY_MAX_S   = 1;
    localparam int          SYNC_DLY_MAX_CYC = CLK_HZ * SYNC_DLY_MAX_S;
    localparam int          DLY_W            = 25;
    localparam int          SYNC_PULSE_NS    = 1000;
    localparam int          SYNC_PULSE_CYC   = (SYNC_PULSE_NS * (CLK_HZ / 1_000_000)) / 1000;
    localparam int          STAT_W           = 16;

    // Output shutdown mask: bit positions of each fault source.
    localparam int          OFF_CUR_LIM  = 0;
    localparam int          OFF_VOLT_LIM = 1;
    localparam int          OFF_PD_CUR   = 2;
    localparam int          OFF_PD_PWR   = 3;
    localparam int          OFF_ILOCK    = 4;
    localparam int          OFF_OPEN     = 7;
    localparam int          OFF_SHORT    = 8;
    localparam int          OFF_TOL      = 9;
    localparam int          OFF_COOL_OFF = 10;
    localparam int          OFF_COOL_LIM = 11;
    localparam int          OFF_HW_ERR   = 12;
    localparam int          OFF_R_LIM    = 13;
    localparam int          OFF_T_LIM    = 14;
    localparam int          OFF_THERMAL  = 15;

    localparam logic [15:0] OUTOFF_RESET  = 16'h9D9E;
    localparam logic [15:0] OUTOFF_FORCED = 16'h9192;
    localparam logic [15:0] OUTOFF_VALID  = 16'hFF9F;
    localparam logic [15:0] EVT_VALID     = 16'h6F9F;
    localparam logic [15:0] MASK_RESET    = 16'h0000;
    localparam logic        DISP_RESET    = 1'b1;

    typedef enum logic [3:0] {
        CMD_SET_DLY     = 4'h0,
        CMD_GET_DLY     = 4'h1,
        CMD_SET_DISP    = 4'h2,
        CMD_GET_DISP    = 4'h3,
        CMD_SET_COND_EN = 4'h4,
        CMD_GET_COND_EN = 4'h5,
        CMD_SET_EVT_EN  = 4'h6,
        CMD_GET_EVT_EN  = 4'h7,
        CMD_SET_OUTOFF  = 4'h8,
        CMD_GET_OUTOFF  = 4'h9,
        CMD_GET_EVT     = 4'hA
    } lsd_cmd_t;

    typedef enum logic [2:0] {
        TMR_IDLE = 3'b001,
        TMR_WAIT = 3'b010,
        TMR_HIGH = 3'b100
    } lsd_tmr_t;
endpackage

/* File: design/lsd_sync_if.sv */
// Link between the command core and the sync output delay timer.
`timescale 1ns/1ps
`default_nettype none
interface lsd_sync_if;
    import lsd_pkg::*;
    logic [DLY_W-1:0] delay;     // Delay in clock cycles.
    logic             enable;    // Pulsed drive mode active.
    logic             fire;      // One-cycle pulse per output pulse rising edge.
    logic             sync_out;  // Delayed sync pulse.
    modport ctrl (output delay, output enable, output fire, input sync_out);
    modport tmr  (input delay, input enable, input fire, output sync_out);
endinterface
`default_nettype wire

/* File: design/lsd_sync_timer.sv */
// Delay timer that raises the pulse sync output after each output pulse.
`timescale 1ns/1ps
`default_nettype none
module lsd_sync_timer
    import lsd_pkg::*;
(
    input  wire logic clk_sys,  // System clock.
    input  wire logic rst,      // Asynchronous reset, active high.
    lsd_sync_if.tmr   sif       // Delay, enable, fire and sync output.
);
    localparam int PW = SYNC_PULSE_CYC;

    typedef struct packed {
        lsd_tmr_t         st;
        logic [DLY_W-1:0] cnt;
        logic [DLY_W-1:0] dly;
        logic             sync;
        logic [DLY_W-1:0] hi;
    } lsd_tmr_st_t;

    lsd_tmr_st_t s_r;
    lsd_tmr_st_t s_nxt;

    always_comb begin
        s_nxt = s_r;
        // Counts the cycles the sync output has stood high; only the width checks read it.
        s_nxt.hi = s_r.sync ? s_r.hi + 1'b1 : '0;
        unique case (s_r.st)
            TMR_IDLE: ;
            TMR_WAIT: begin
                if (s_r.cnt == s_r.dly) begin
                    s_nxt.st   = TMR_HIGH;
                    s_nxt.sync = 1'b1;
                    s_nxt.cnt  = '0;
                end else begin
                    s_nxt.cnt = s_r.cnt + 1'b1;
                end
            end
            TMR_HIGH: begin
                if (s_r.cnt == DLY_W'(PW - 1)) begin
                    s_nxt.st   = TMR_IDLE;
                    s_nxt.sync = 1'b0;
                end else begin
                    s_nxt.cnt = s_r.cnt + 1'b1;
                end
            end
            default: begin
                s_nxt.st   = TMR_IDLE;
                s_nxt.sync = 1'b0;
            end
        endcase
        // A new pulse restarts the delay, so the sync edge always follows the latest pulse.
        if (sif.enable && sif.fire) begin
            s_nxt.st   = TMR_WAIT;
            s_nxt.cnt  = '0;
            s_nxt.dly  = sif.delay;
            s_nxt.sync = 1'b0;
        end else if (!sif.enable) begin
            s_nxt.st   = TMR_IDLE;
            s_nxt.sync = 1'b0;
        end
    end

    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            s_r <= '{st: TMR_IDLE, cnt: '0, dly: '0, sync: 1'b0, hi: '0};
        end else begin
            s_r <= s_nxt;
        end
    end

    assign sif.sync_out = s_r.sync;

    property p_sync_rise;
        @(posedge clk_sys) disable iff (rst)
        $rose(s_r.sync) |-> $past(s_r.st) == TMR_WAIT && $past(s_r.cnt) == $past(s_r.dly);
    endproperty
    a_sync_rise: assert property (p_sync_rise) else $error("sync rose before delay elapsed");

    // A pulse cut short by a new fire or by leaving pulsed mode is exempt from the full width.
    property p_sync_width;
        @(posedge clk_sys) disable iff (rst)
        $fell(s_r.sync) && $past(sif.enable) && !$past(sif.fire) |-> $past(s_r.hi) == DLY_W'(PW - 1);
    endproperty
    a_sync_width: assert property (p_sync_width) else $error("sync pulse width wrong");

    property p_sync_max;
        @(posedge clk_sys) disable iff (rst)
        s_r.sync |-> s_r.hi < DLY_W'(PW);
    endproperty
    a_sync_max: assert property (p_sync_max) else $error("sync pulse stood too long");
endmodule
`default_nettype wire

/* File: verif/laser_status_event_shutdown_tb_top.sv */
// Self-checking testbench for the laser status, event and shutdown block.
`timescale 1ns/1ps
`default_nettype none
module laser_status_event_shutdown_tb_top;
    import lsd_pkg::*;
    localparam int MAXD = 200;
    logic        clk_sys = 1'b0;
    logic        rst = 1'b1;
    logic        cmd_valid;
    logic [3:0]  cmd_op;
    logic [31:0] cmd_data;
    logic        rsp_valid;
    logic [31:0] rsp_data;
    logic        pulsed_drive_mode = 1'b1;
    logic        drive_pulse = 1'b0;
    logic [15:0] cond_in = 16'h0000;
    logic [15:0] event_in = 16'h0000;
    logic [15:0] fault_in = 16'h0000;
    logic        pulse_sync_output;
    logic        laser_off;
    logic        panel_locked;
    logic        status_summary;
    int          err_count = 0;
    int          n_compared = 0;

    always #20 clk_sys = ~clk_sys;

    lsd_core #(.MAX_DLY_CYC(MAXD)) i_dut (.clk_sys(clk_sys), .rst(rst), .cmd_valid(cmd_valid), .cmd_op(cmd_op),
        .cmd_data(cmd_data), .rsp_valid(rsp_valid), .rsp_data(rsp_data), .pulsed_drive_mode(pulsed_drive_mode),
        .drive_pulse(drive_pulse), .cond_in(cond_in), .event_in(event_in), .fault_in(fault_in),
        .pulse_sync_output(pulse_sync_output), .laser_off(laser_off), .panel_locked(panel_locked),
        .status_summary(status_summary));

    lsd_host_model i_host (.clk_sys(clk_sys), .cmd_valid(cmd_valid), .cmd_op(cmd_op), .cmd_data(cmd_data),
        .rsp_valid(rsp_valid), .rsp_data(rsp_data));

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        n_compared++;
        if (got !== exp) begin
            err_count++;
            $display("[ERR] %0t ns: got %h expected %h", $time, got, exp);
        end
    endtask

    task automatic wt(input int n);
        repeat (n) @(posedge clk_sys);
        #1;
    endtask

    task automatic rd(input logic [3:0] op, input logic [31:0] exp);
        logic [31:0] d;
        logic        ok;
        i_host.query(op, d, ok);
        chk({31'h0, ok}, 32'h0000_0001);
        chk(d, exp);
    endtask

    // Measures edges from the pulse rise to the sync rise, then the sync width.
    task automatic sync_run(input int dly);
        int k;
        int w;
        int e;
        e = (dly > MAXD) ? MAXD : dly;
        i_host.send(CMD_SET_DLY, dly);
        rd(CMD_GET_DLY, e);
        drive_pulse = 1'b1;
        k = 0;
        w = 0;
        while (pulse_sync_output !== 1'b1 && k < 400) begin
            @(posedge clk_sys);
            #1;
            k++;
        end
        chk(k, 5 + e);
        while (pulse_sync_output === 1'b1 && w < 100) begin
            @(posedge clk_sys);
            #1;
            w++;
        end
        chk(w, SYNC_PULSE_CYC);
        drive_pulse = 1'b0;
        wt(4);
    endtask

    task automatic test_done;
        $display("Comparisons %0d, mismatches %0d", n_compared, err_count);
        if (err_count == 0 && n_compared > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask

    initial begin
        #400_000;
        err_count++;
        test_done;
    end

    initial begin
        logic [31:0] d;
        logic        ok;
        logic        hit;
        repeat (8) @(posedge clk_sys);
        #1;
        rst = 1'b0;
        chk(laser_off, 0);
        chk(panel_locked, 0);
        rd(CMD_GET_OUTOFF, 32'h0000_9D9E);
        rd(CMD_GET_COND_EN, 32'h0000_0000);
        rd(CMD_GET_EVT_EN, 32'h0000_0000);
        rd(CMD_GET_EVT, 32'h0000_0000);
        rd(CMD_GET_DISP, 32'h0000_0001);
        i_host.query(4'hB, d, ok);
        chk(ok, 0);
        // Each fault alone, first with only the forced bits enabled, then with all bits but 5 and 6 enabled.
        for (int m = 0; m < 2; m++) begin
            i_host.send(CMD_SET_OUTOFF, m ? 32'h0000_FFFF : 32'h0000_0000);
            rd(CMD_GET_OUTOFF, m ? 32'h0000_FF9F : 32'h0000_9192);
            for (int i = 0; i < 16; i++) begin
                fault_in = 16'h0001 << i;
                wt(4);
                chk(laser_off, m ? OUTOFF_VALID[i] : OUTOFF_FORCED[i]);
                fault_in = 16'h0000;
                wt(4);
                chk(laser_off, 0);
            end
        end
        for (int i = 0; i < 16; i++) begin
            event_in = 16'h0001 << i;
            wt(1);
            event_in = 16'h0000;
            wt(5);
            rd(CMD_GET_EVT, (32'h0000_0001 << i) & EVT_VALID);
            rd(CMD_GET_EVT, 32'h0000_0000);
        end
        i_host.send(CMD_SET_EVT_EN, 32'h0000_0001);
        rd(CMD_GET_EVT_EN, 32'h0000_0001);
        event_in = 16'h0002;
        wt(1);
        event_in = 16'h0000;
        wt(6);
        chk(status_summary, 0);
        rd(CMD_GET_EVT, 32'h0000_0002);
        event_in = 16'h0001;
        wt(1);
        event_in = 16'h0000;
        wt(6);
        chk(status_summary, 1);
        wt(10);
        chk(status_summary, 1);
        rd(CMD_GET_EVT, 32'h0000_0001);
        wt(3);
        chk(status_summary, 0);
        i_host.send(CMD_SET_EVT_EN, 32'h0000_0000);
        i_host.send(CMD_SET_COND_EN, 32'h0000_0004);
        rd(CMD_GET_COND_EN, 32'h0000_0004);
        cond_in = 16'h0008;
        wt(5);
        chk(status_summary, 0);
        cond_in = 16'h0004;
        wt(5);
        chk(status_summary, 1);
        cond_in = 16'h0000;
        wt(5);
        chk(status_summary, 0);
        i_host.send(CMD_SET_DISP, 32'h0000_0000);
        wt(1);
        chk(panel_locked, 1);
        rd(CMD_GET_DISP, 32'h0000_0000);
        i_host.send(CMD_SET_OUTOFF, 32'h0000_0000);
        i_host.send(CMD_SET_DISP, 32'h0000_0000);
        wt(20);
        chk(panel_locked, 1);
        rd(CMD_GET_OUTOFF, 32'h0000_9192);
        i_host.send(CMD_SET_DISP, 32'h0000_0001);
        wt(1);
        chk(panel_locked, 0);
        sync_run(0);
        sync_run(10);
        sync_run(300);
        // Outside pulsed mode a pulse edge must never reach the sync output.
        pulsed_drive_mode = 1'b0;
        drive_pulse = 1'b1;
        hit = 1'b0;
        repeat (260) begin
            @(posedge clk_sys);
            #1;
            hit = hit | pulse_sync_output;
        end
        chk(hit, 0);
        test_done;
    end
endmodule
`default_nettype wire

/* File: verif/lsd_host_model.sv */
// Host side model that issues remote commands and collects query answers.
`timescale 1ns/1ps
`default_nettype none
module lsd_host_model
    import lsd_pkg::*;
(
    input  wire logic        clk_sys,    // System clock.
    output logic             cmd_valid,  // Command strobe.
    output logic      [3:0]  cmd_op,     // Command code.
    output logic      [31:0] cmd_data,   // Command argument.
    input  wire logic        rsp_valid,  // Answer strobe.
    input  wire logic [31:0] rsp_data    // Answer value.
);
    initial begin
        cmd_valid = 1'b0;
        cmd_op    = 4'h0;
        cmd_data  = 32'h0000_0000;
    end

    // Idle argument lines show the inverse of the last word, so a stale value is never read as valid.
    task automatic send(input logic [3:0] op, input logic [31:0] d);
        @(posedge clk_sys);
        #1;
        cmd_valid = 1'b1;
        cmd_op    = op;
        cmd_data  = d;
        @(posedge clk_sys);
        #1;
        cmd_valid = 1'b0;
        cmd_op    = ~op;
        cmd_data  = ~d;
    endtask

    // The answer stands for one cycle only; send returns just after the edge that took the command,
    // which is exactly while the answer stands.
    task automatic query(input logic [3:0] op, output logic [31:0] d, output logic ok);
        send(op, 32'h0000_0000);
        ok = rsp_valid;
        d  = rsp_data;
    endtask
endmodule
`default_nettype wire
